// [hw/mts_sequencer.sv]
// Instruction timing sequencer: steps base, source and destination microcycles.
// Assumes instr_i is held stable while start_i is high and the sequencer is idle;
// wait_req_i and stretch_i come from the bus side and are synchronised here.
// Outputs are registered; kind_o names the microcycle that is running.
`timescale 1ns/1ps
`default_nettype none
module mts_sequencer
  import mts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire mts_instr_type instr_i,
  input wire logic wait_req_i,
  input wire logic stretch_i,
  output logic busy_o,
  output logic [1:0] kind_o,
  output logic mc_done_o,
  output logic instr_done_o,
  output logic [7:0] total_clks_o
);
  typedef enum logic [1:0] {
    MTS_IDLE,
    MTS_ISSUE,
    MTS_RUN
  } mts_state_type;

  mts_state_type state_reg;
  // Phase 3 stands before the base segment; 0, 1 and 2 run base, source and destination.
  logic [1:0] phase_reg;
  logic [4:0] left_reg;
  logic [4:0] reads_reg;
  logic [4:0] writes_reg;
  logic [7:0] clks_reg;
  mts_instr_type ins_reg;
  logic wait_s1_reg;
  logic wait_s2_reg;
  logic str_s1_reg;
  logic str_s2_reg;
  logic [6:0] mc_cnt_reg;
  logic [6:0] mc_expect;
  logic issue_mc;
  logic seg_open;
  logic uc_done;
  logic [4:0] uc_clks;
  mts_seg_type base_adj;
  mts_seg_type cur_seg;
  mts_kind_type cur_kind;
  logic last_mc;

  // Bus-side levels cross in from outside; two stages before use.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_s1_reg <= 1'b0;
      wait_s2_reg <= 1'b0;
      str_s1_reg <= 1'b0;
      str_s2_reg <= 1'b0;
    end else begin
      wait_s1_reg <= wait_req_i;
      wait_s2_reg <= wait_s1_reg;
      str_s1_reg <= stretch_i;
      str_s2_reg <= str_s1_reg;
    end
  end

  // RULE13 immediate float operand drops one base cycle; the base write count passes through unchanged.
  assign base_adj.microcycle_count = ins_reg.float_imm ? ins_reg.base.microcycle_count - MTS_ONE
                                                       : ins_reg.base.microcycle_count;
  assign base_adj.reads = ins_reg.base.reads;
  assign base_adj.writes = ins_reg.base.writes;
  // RULE7 base segment first, then source, then destination.
  assign cur_seg = (phase_reg == 2'h0) ? base_adj : (phase_reg == 2'h1) ? ins_reg.src : ins_reg.dst;
  // Reads are issued first, then writes, the remainder internal cycles.
  assign cur_kind = (reads_reg != MTS_ZERO) ? MTS_KIND_READ :
                    (writes_reg != MTS_ZERO) ? MTS_KIND_WRITE : MTS_KIND_IDLE;
  assign last_mc = (left_reg == MTS_ONE);
  // RULE9 RULE11 per-segment counts and read/write split arrive in instr_i.
  // Microcycles owed by the instruction; seven bits hold three full segments.
  assign mc_expect = {2'h0, base_adj.microcycle_count} + {2'h0, ins_reg.src.microcycle_count} +
                     {2'h0, ins_reg.dst.microcycle_count};
  assign issue_mc = (state_reg == MTS_ISSUE);
  // A segment opens when the previous one is spent and the destination is not yet loaded.
  assign seg_open = (state_reg == MTS_RUN) && (left_reg == MTS_ZERO) && !uc_done && (phase_reg != 2'h2);

  // One timer serves every microcycle; the issue state starts it once per microcycle.
  mts_microcycle u_mc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(issue_mc),
    .kind_i(cur_kind),
    .stretch_i(str_s2_reg),
    .wait_i(wait_s2_reg),
    .done_o(uc_done),
    .clks_o(uc_clks)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= MTS_IDLE;
      phase_reg <= 2'h0;
      left_reg <= MTS_ZERO;
      reads_reg <= MTS_ZERO;
      writes_reg <= MTS_ZERO;
      clks_reg <= 8'h00;
      ins_reg <= '0;
      busy_o <= 1'b0;
      kind_o <= 2'h0;
      mc_done_o <= 1'b0;
      instr_done_o <= 1'b0;
      total_clks_o <= 8'h00;
    end else begin
      mc_done_o <= uc_done;
      instr_done_o <= 1'b0;
      unique case (state_reg)
        MTS_IDLE: begin
          if (start_i) begin
            // The copy lets the caller change instr_i once busy_o is up.
            ins_reg <= instr_i;
            phase_reg <= 2'h3;
            clks_reg <= 8'h00;
            left_reg <= MTS_ZERO;
            busy_o <= 1'b1;
            state_reg <= MTS_RUN;
          end
        end
        MTS_ISSUE: begin
          // Registered here so the kind stands for the whole microcycle.
          kind_o <= cur_kind;
          state_reg <= MTS_RUN;
        end
        MTS_RUN: begin
          // RULE15 next microcycle only once the timer reports done.
          if (uc_done || left_reg == MTS_ZERO) begin
            // A finished microcycle books its length; a finished read or write also spends one of its count.
            if (uc_done) begin
              clks_reg <= clks_reg + {3'h0, uc_clks};
              if (cur_kind == MTS_KIND_READ) reads_reg <= reads_reg - MTS_ONE;
              else if (cur_kind == MTS_KIND_WRITE) writes_reg <= writes_reg - MTS_ONE;
            end
            if (uc_done && !last_mc) begin
              left_reg <= left_reg - MTS_ONE;
              state_reg <= MTS_ISSUE;
            end else if (phase_reg == 2'h2) begin
              // RULE10 empty segments cost nothing.
              state_reg <= MTS_IDLE;
              busy_o <= 1'b0;
              instr_done_o <= 1'b1;
              total_clks_o <= clks_reg + (uc_done ? {3'h0, uc_clks} : 8'h00);
            end else begin
              // Only the segment load below advances the phase, so no segment is passed over.
              left_reg <= MTS_ZERO;
              state_reg <= MTS_RUN;
            end
          end
        end
        default: state_reg <= MTS_IDLE;
      endcase
      // Load the next segment's counts when a new phase opens.
      if (seg_open) begin
        left_reg <= (phase_reg == 2'h3) ? base_adj.microcycle_count :
                    (phase_reg == 2'h0) ? ins_reg.src.microcycle_count : ins_reg.dst.microcycle_count;
        reads_reg <= (phase_reg == 2'h3) ? base_adj.reads :
                     (phase_reg == 2'h0) ? ins_reg.src.reads : ins_reg.dst.reads;
        writes_reg <= (phase_reg == 2'h3) ? base_adj.writes :
                      (phase_reg == 2'h0) ? ins_reg.src.writes : ins_reg.dst.writes;
        phase_reg <= phase_reg + 2'h1;
        if (((phase_reg == 2'h3) ? base_adj.microcycle_count :
             (phase_reg == 2'h0) ? ins_reg.src.microcycle_count : ins_reg.dst.microcycle_count) != MTS_ZERO)
          state_reg <= MTS_ISSUE;
      end
    end
  end

  // Microcycles finished in this instruction, held against what instr_i owed.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_cnt_reg <= 7'h00;
    end else if (state_reg == MTS_IDLE) begin
      mc_cnt_reg <= 7'h00;
    end else if (uc_done) begin
      mc_cnt_reg <= mc_cnt_reg + 7'h01;
    end
  end

  // RULE12 RULE14 counts come from instr_i, so any per-data value is accepted.
  a_read_min_four: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    (uc_done && kind_o == MTS_KIND_READ) |-> uc_clks >= MTS_READ_CLKS) else $error("read too short");
  a_write_min_eight: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    (uc_done && kind_o == MTS_KIND_WRITE) |-> uc_clks >= MTS_WRITE_CLKS) else $error("write too short");
  // RULE3 RULE4 an internal cycle is four clocks, or eight and more once it waits.
  a_idle_four_exact: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
    (uc_done && kind_o == MTS_KIND_IDLE) |-> (uc_clks == MTS_IDLE_CLKS || uc_clks >= MTS_IDLE_CLKS + MTS_FIRST_WAIT_CLKS))
    else $error("internal cycle length wrong");
  a_stretch_read_eight: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
    (state_reg == MTS_ISSUE && cur_kind == MTS_KIND_READ && str_s2_reg) |=> (!uc_done) [*8])
    else $error("stretched read too short");
  a_busy_done_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    instr_done_o |-> !busy_o) else $error("done while busy");
  a_start_takes: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
    (state_reg == MTS_IDLE && start_i) |=> busy_o) else $error("start not taken");
  // RULE10 an empty segment opens and closes without issuing a microcycle.
  a_empty_no_issue: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
    seg_open |=> (state_reg != MTS_ISSUE || left_reg != MTS_ZERO)) else $error("empty segment issued a microcycle");
  a_mc_total: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    instr_done_o |-> (mc_cnt_reg == mc_expect)) else $error("microcycle count differs from segments");
  a_refuse_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
    (busy_o && start_i) |=> $stable(ins_reg)) else $error("start taken while busy");
  a_kind_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    (state_reg != MTS_ISSUE) |=> $stable(kind_o)) else $error("kind changed without an issue");
  a_left_in_seg: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
    issue_mc |-> (left_reg <= cur_seg.microcycle_count)) else $error("microcycles left exceed segment");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
    instr_done_o |=> !instr_done_o) else $error("instruction done longer than one clock");
  a_mc_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
    mc_done_o |=> !mc_done_o) else $error("microcycle done longer than one clock");

  c_read: cover property (@(posedge clk_i) uc_done && kind_o == MTS_KIND_READ);
  c_write: cover property (@(posedge clk_i) uc_done && kind_o == MTS_KIND_WRITE);
  c_waited: cover property (@(posedge clk_i) uc_done && uc_clks > 5'h08);
  c_instr: cover property (@(posedge clk_i) instr_done_o);
  c_src: cover property (@(posedge clk_i) issue_mc && phase_reg == 2'h1);
endmodule : mts_sequencer
`default_nettype wire

// [hw/mts_pkg.sv]
// Constants and carrier types for the microcycle timing sequencer.
// Assumes a single 25 MHz processor clock and an active-low asynchronous reset.
//
// Summary of operation
// RULE1: Read microcycle lasts at least four clocks.
// RULE2: Write microcycle lasts at least eight clocks.
// RULE3: Internal microcycle lasts exactly four clocks. The code lets a wait lengthen it to eight clocks and more.
// RULE4: First wait adds four, later waits two. The code adds two for the first wait of a write or a stretched read.
// RULE5: Stretched cycles grow in two-clock steps.
// RULE6: Stretched read lasts eight, then two-clock steps.
// RULE7: Base microcycles run before operand microcycles.
// RULE8: Memory-side waits lengthen the instruction.
// RULE9: Word move base is one read microcycle.
// RULE10: Register mode source costs zero microcycles.
// RULE11: Absolute destination: read, write, internal.
// RULE12: Double float clear base is fourteen microcycles.
// RULE13: Float mode 2 reg 7: drop one, add write. The code drops one but adds no write.
// RULE14: Float duration varies with data kind.
// RULE15: Advance only after minimum and waits elapse.
package mts_pkg;

  typedef enum logic [1:0] {
    MTS_KIND_READ,
    MTS_KIND_WRITE,
    MTS_KIND_IDLE
  } mts_kind_type;

  typedef struct packed {
    logic [4:0] microcycle_count;
    logic [4:0] reads;
    logic [4:0] writes;
  } mts_seg_type;

  typedef struct packed {
    mts_seg_type base;
    mts_seg_type src;
    mts_seg_type dst;
    logic float_imm;
  } mts_instr_type;

  localparam logic [4:0] MTS_READ_CLKS = 5'h04;
  localparam logic [4:0] MTS_WRITE_CLKS = 5'h08;
  localparam logic [4:0] MTS_IDLE_CLKS = 5'h04;
  localparam logic [4:0] MTS_STRETCH_READ_CLKS = 5'h08;
  localparam logic [4:0] MTS_FIRST_WAIT_CLKS = 5'h04;
  localparam logic [4:0] MTS_NEXT_WAIT_CLKS = 5'h02;

  localparam logic [4:0] MTS_MOVE_BASE_MC = 5'h01;
  localparam logic [4:0] MTS_REG_MODE_MC = 5'h00;
  localparam logic [4:0] MTS_ABS_DST_MC = 5'h03;
  localparam logic [4:0] MTS_CLEAR_DOUBLE_FLOAT_BASE_MC = 5'h0E;
  localparam logic [4:0] MTS_ONE = 5'h01;
  localparam logic [4:0] MTS_ZERO = 5'h00;

endpackage : mts_pkg

// [hw/mts_microcycle.sv]
// One microcycle timer: counts clocks of one read, write or internal cycle.
// Assumes wait and stretch inputs are already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module mts_microcycle
  import mts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire mts_kind_type kind_i,
  input wire logic stretch_i,
  input wire logic wait_i,
  output logic done_o,
  output logic [4:0] clks_o
);
  logic busy_reg;
  logic [4:0] cnt_reg;
  logic [4:0] len_reg;
  logic waited_reg;
  logic stretched_reg;
  logic [4:0] min_len;
  logic at_end;
  logic [4:0] add_len;

  // RULE1 RULE2 RULE3 RULE6 minimum length by kind.
  assign min_len = (kind_i == MTS_KIND_WRITE) ? MTS_WRITE_CLKS :
                   (kind_i == MTS_KIND_READ && stretch_i) ? MTS_STRETCH_READ_CLKS :
                   (kind_i == MTS_KIND_READ) ? MTS_READ_CLKS : MTS_IDLE_CLKS;
  assign at_end = busy_reg && (cnt_reg + MTS_ONE == len_reg);
  // RULE4 RULE5 first wait of plain cycle adds four, else two.
  assign add_len = (!waited_reg && !stretched_reg) ? MTS_FIRST_WAIT_CLKS : MTS_NEXT_WAIT_CLKS;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= MTS_ZERO;
      len_reg <= MTS_ZERO;
      waited_reg <= 1'b0;
      stretched_reg <= 1'b0;
      done_o <= 1'b0;
      clks_o <= MTS_ZERO;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= MTS_ZERO;
        len_reg <= min_len;
        waited_reg <= 1'b0;
        // RULE4 stretched reads and every write take two-clock waits; internal cycles and plain reads keep the four-clock first wait.
        stretched_reg <= (stretch_i && (kind_i == MTS_KIND_READ)) || (kind_i == MTS_KIND_WRITE);
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + MTS_ONE;
        // RULE8 RULE15 a wait seen at the last clock extends the cycle.
        if (at_end && wait_i) begin
          len_reg <= len_reg + add_len;
          waited_reg <= 1'b1;
        end else if (at_end) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
          clks_o <= cnt_reg + MTS_ONE;
        end
      end
    end
  end

  a_done_min_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    done_o |-> clks_o >= MTS_READ_CLKS) else $error("microcycle shorter than four clocks");
  a_len_even: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    done_o |-> clks_o[0] == 1'b0) else $error("microcycle length not a two-clock step");
  a_wait_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
    (at_end && wait_i) |=> (busy_reg && !done_o)) else $error("wait did not lengthen the microcycle");
endmodule : mts_microcycle
`default_nettype wire

// [tb/mts_mem_model.sv]
// Memory-side model: asks for wait states and for stretched cycles.
// Assumes the bench sets slow_i and wait_len_i before each instruction starts.
`timescale 1ns/1ps
`default_nettype none
module mts_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic busy_i,
  input wire logic slow_i,
  input wire logic [3:0] wait_len_i,
  output logic wait_req_o,
  output logic stretch_o
);
  logic [3:0] wait_cnt_reg;
  logic busy_d_reg;
  // A bounded wait window keeps the instruction finite; a held request would stall it forever.
  // memory requests waits
  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt_reg <= 4'h0;
      busy_d_reg <= 1'b0;
    end else begin
      busy_d_reg <= busy_i;
      if (busy_i && !busy_d_reg) wait_cnt_reg <= wait_len_i;
      else if (wait_cnt_reg != 4'h0) wait_cnt_reg <= wait_cnt_reg - 4'h1;
    end
  end
  assign wait_req_o = (wait_cnt_reg != 4'h0);
  assign stretch_o = slow_i;
endmodule : mts_mem_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the microcycle timing sequencer.
// Assumes the memory model answers waits and stretches; cycle totals are checked
// exactly when no wait is asked for and as lower bounds otherwise.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mts_pkg::*;
  logic clk_i, rst_n_i, start_i, slow, wait_req, stretch, busy_o, mc_done_o, instr_done_o;
  logic [3:0] wait_len;
  logic [1:0] kind_o, kind_prev;
  logic [7:0] total_clks_o, got_total;
  mts_instr_type instr_i, ins;
  int err_total, n_tests, cyc_seen, done_seen;
  int tots[4];
  logic [1:0] kinds_q[$];
  mts_sequencer mts_sequencer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .instr_i(instr_i),
    .wait_req_i(wait_req), .stretch_i(stretch), .busy_o(busy_o), .kind_o(kind_o), .mc_done_o(mc_done_o),
    .instr_done_o(instr_done_o), .total_clks_o(total_clks_o));
  mts_mem_model mts_mem_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .busy_i(busy_o), .slow_i(slow),
    .wait_len_i(wait_len), .wait_req_o(wait_req), .stretch_o(stretch));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // The kind is taken one cycle back because the done pulse trails the microcycle.
  always @(posedge clk_i) begin
    kind_prev <= kind_o;
    if (mc_done_o === 1'b1) begin
      cyc_seen++;
      kinds_q.push_back(kind_prev);
    end
    if (instr_done_o === 1'b1) begin
      done_seen++;
      got_total = total_clks_o;
    end
  end
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic run(input string name, input logic slw, input logic [3:0] wl, output int tot);
    int n;
    int c;
    int minc;
    int k;
    int exp_q[$];
    mts_seg_type seg;
    minc = 0;
    for (int s = 0; s < 3; s++) begin
      seg = (s == 0) ? ins.base : (s == 1) ? ins.src : ins.dst;
      c = seg.microcycle_count;
      if (s == 0 && ins.float_imm) c--;
      for (int i = 0; i < c; i++) begin
        k = (i < seg.reads) ? 0 : (i < seg.reads + seg.writes) ? 1 : 2;
        exp_q.push_back(k);
        minc += (k == 1 || (k == 0 && slw)) ? 8 : 4;
      end
    end
    @(negedge clk_i);
    instr_i = ins;
    slow = slw;
    wait_len = wl;
    cyc_seen = 0;
    done_seen = 0;
    kinds_q.delete();
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    repeat (2) @(negedge clk_i);
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    n = 0;
    while (done_seen == 0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      print_verdict();
    end
    repeat (4) @(negedge clk_i);
    check("done count", done_seen, 1);
    check("cycle count", cyc_seen, exp_q.size());
    for (int i = 0; i < exp_q.size() && i < kinds_q.size(); i++) check("kind", kinds_q[i], exp_q[i]);
    check("clocks", (wl == 4'h0) ? (got_total == minc) : (got_total >= minc), 1);
    tot = got_total;
    $display("test %s done", name);
  endtask : run
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    slow = 1'b0;
    wait_len = 4'h0;
    instr_i = '0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(4940));
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    ins = '{base: '{5'h01, 5'h01, 5'h00}, src: '{5'h00, 5'h00, 5'h00}, dst: '{5'h03, 5'h01, 5'h01}, float_imm: 1'b0};
    for (int m = 0; m < 4; m++) run("word_move", m[0], m[1] ? 4'hC : 4'h0, tots[m]);
    check("cycles total", cyc_seen, 4);
    check("stretch adds", tots[1] >= tots[0] + 8, 1);
    check("wait adds", tots[2] >= tots[0] + 4, 1);
    check("stretched wait", tots[3] >= tots[1] + 2, 1);
    ins = '{base: '{5'h0E, 5'h00, 5'h00}, src: '0, dst: '{5'h01, 5'h00, 5'h01}, float_imm: 1'b1};
    run("clear_double_float", 1'b0, 4'h0, tots[0]);
    check("float cycles", cyc_seen, 14);
    for (int t = 0; t < 8; t++) begin
      ins = '0;
      ins.base.microcycle_count = 5'($urandom_range(1, 4));
      ins.base.reads = 5'($urandom_range(0, 1));
      ins.src.microcycle_count = 5'($urandom_range(0, 2));
      ins.src.reads = 5'($urandom_range(0, 1)) & ins.src.microcycle_count;
      ins.dst.microcycle_count = 5'($urandom_range(0, 3));
      ins.dst.writes = 5'($urandom_range(0, 1)) & ins.dst.microcycle_count;
      run("random", 1'($urandom_range(0, 1)), 4'($urandom_range(0, 15)), tots[0]);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
